// ### fspc_pkg.sv
// Package with constants, types and state codes for flash self-program control
// Summary of operation
// RULE1 - Z=0x0001 armed load returns lock bits
// RULE2 - Auto-clear read select and enable on timeout
// RULE3 - Cleared arm restores normal program reads
// RULE4 - Z=0x0000 armed load returns fuse low
// RULE5 - Z=0x0003 armed load returns fuse high
// RULE6 - Z=0x0002 armed load returns fuse extended
// RULE7 - Programmed bits read zero, unprogrammed one
// RULE8 - Reset never aborts a running flash write; reset still clears buf_valid_reg, so buf_word_o streams 16'hFFFF after it
// RULE9 - Erase and write last 3.7 to 4.5 ms
// RULE10 - Busy flag bit 6 always reads zero
// RULE11 - Reserved bit 5 always reads zero
// RULE12 - Ready interrupt requested while enable clear
// RULE13 - Ready interrupt suppressed during EEPROM or store
// RULE14 - Buffer clear write wipes temporary page buffer
// RULE15 - Z0 selects lock or fuse readback
// RULE16 - Write command programs buffer into selected page
// RULE17 - Write command auto-clears, CPU halted meanwhile
// RULE18 - Erase command erases page from upper pointer
// RULE19 - Erase command auto-clears, CPU halted meanwhile
// RULE20 - Enable alone stores R1:R0 into buffer word
// RULE21 - Enable arms four cycles, held during operation
// RULE22 - Illegal low five bit patterns are ignored
// RULE23 - EEPROM write blocks programming and fuse reads
// RULE24 - Buffer erased after page write and reset
// RULE25 - Software erases with 00000011 then store
// RULE26 - Writes to read-only bits change nothing
package fspc_pkg;
  localparam logic [5:0] FSPC_CSR_ADDR = 6'h37;
  localparam logic [7:0] FSPC_CSR_RESET = 8'h00;
  localparam int FSPC_BIT_EN = 0;
  localparam int FSPC_BIT_ERS = 1;
  localparam int FSPC_BIT_WRT = 2;
  localparam int FSPC_BIT_LFR = 3;
  localparam int FSPC_BIT_RWWRE = 4;
  localparam int FSPC_BIT_RES = 5;
  localparam int FSPC_BIT_BUSY = 6;
  localparam int FSPC_BIT_IE = 7;
  localparam logic [4:0] FSPC_CMD_STORE = 5'h01;
  localparam logic [4:0] FSPC_CMD_ERASE = 5'h03;
  localparam logic [4:0] FSPC_CMD_WRITE = 5'h05;
  localparam logic [4:0] FSPC_CMD_LFREAD = 5'h09;
  localparam logic [4:0] FSPC_CMD_RWWRE = 5'h11;
  localparam logic [2:0] FSPC_STORE_WIN = 3'h4;
  localparam logic [2:0] FSPC_LOAD_WIN = 3'h3;
  localparam logic [15:0] FSPC_Z_FUSE_LO = 16'h0000;
  localparam logic [15:0] FSPC_Z_LOCK = 16'h0001;
  localparam logic [15:0] FSPC_Z_FUSE_EXT = 16'h0002;
  localparam logic [15:0] FSPC_Z_FUSE_HI = 16'h0003;
  localparam int FSPC_PAGE_WORDS = 32;
  localparam int FSPC_WORD_AW = 5;
  localparam int FSPC_CLK_HZ = 50000000;
  localparam int FSPC_OSC_DIV = 50;
  localparam int FSPC_OP_MIN_US = 3700;
  localparam int FSPC_OP_MAX_US = 4500;
  localparam int FSPC_OSC_HZ = FSPC_CLK_HZ / FSPC_OSC_DIV;
  localparam int FSPC_OP_TICKS = (FSPC_OP_MIN_US * (FSPC_OSC_HZ / 1000) + 999) / 1000;
  typedef enum logic [3:0] {
    FSPC_IDLE = 4'b0001,
    FSPC_ARMED = 4'b0010,
    FSPC_ERASING = 4'b0100,
    FSPC_WRITING = 4'b1000
  } fspc_state_t;
  typedef struct packed {
    logic [7:0] lock;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] fuse_ext;
  } fspc_fuses_t;
  typedef struct packed {
    logic we;
    logic [FSPC_WORD_AW-1:0] word;
    logic [15:0] data;
  } fspc_buf_wr_t;
endpackage : fspc_pkg

// ### fspc_op_timer.sv
// Oscillator-tick timer for flash erase and write durations
`timescale 1ns/1ps
module fspc_op_timer #(
  parameter int TICKS = fspc_pkg::FSPC_OP_TICKS
) (
  input wire logic sys_clk_i,
  input wire logic start_i,
  output logic done_o
);
  import fspc_pkg::*;
  logic [7:0] div_reg;
  logic osc_tick;
  logic [15:0] cnt_reg;
  logic run_reg;
  ////////////////////////////////////////////////////////////
  // Calibrated oscillator tick as enable; not reset so ops survive reset
  assign osc_tick = (div_reg == 8'(FSPC_OSC_DIV - 1));
  always_ff @(posedge sys_clk_i) begin
    if (osc_tick || start_i) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    done_o <= 1'b0;
    if (start_i) begin
      run_reg <= 1'b1;
      cnt_reg <= 16'(TICKS); // [RULE9]
    end else if (run_reg && osc_tick) begin
      if (cnt_reg == 16'h0001) begin
        run_reg <= 1'b0;
        done_o <= 1'b1;
      end
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end
endmodule : fspc_op_timer

// ### fspc_top.sv
// Self-program control register, timed arming, page buffer and fuse readback
`timescale 1ns/1ps
module fspc_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic io_we_i,
  input wire logic io_re_i,
  input wire logic [5:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic store_instr_i,
  input wire logic load_instr_i,
  input wire logic [15:0] zptr_i,
  input wire logic [15:0] r1r0_i,
  input wire logic [7:0] prog_byte_i,
  input wire logic global_irq_en_i,
  input wire logic eeprom_write_busy_i,
  input wire fspc_pkg::fspc_fuses_t fuses_i,
  output logic [7:0] load_data_o,
  output logic load_valid_o,
  output logic cpu_halt_o,
  output logic ready_irq_o,
  output logic page_erase_o,
  output logic page_write_o,
  output logic [15:0] page_addr_o,
  output logic [15:0] buf_word_o,
  output logic [fspc_pkg::FSPC_WORD_AW-1:0] buf_rd_idx_o
);
  import fspc_pkg::*;
  fspc_state_t state_reg;
  logic irq_en_reg;
  logic [4:0] cmd_reg;
  logic [2:0] win_reg;
  logic [15:0] page_buf [FSPC_PAGE_WORDS];
  logic [FSPC_PAGE_WORDS-1:0] buf_valid_reg;
  logic ee_busy_s1_reg;
  logic ee_busy_reg;
  logic gie_s1_reg;
  logic gie_reg;
  logic csr_sel;
  logic csr_wr;
  logic legal_wr;
  logic store_ok;
  logic lf_armed;
  logic lf_hit;
  logic op_start;
  logic op_done;
  logic busy_op;
  logic buf_clear;
  fspc_buf_wr_t bw;
  logic [7:0] csr_view;
  ////////////////////////////////////////////////////////////
  // Synchronise EEPROM busy and global enable
  always_ff @(posedge sys_clk_i) begin
    ee_busy_s1_reg <= eeprom_write_busy_i;
    ee_busy_reg <= ee_busy_s1_reg;
    gie_s1_reg <= global_irq_en_i;
    gie_reg <= gie_s1_reg;
  end
  ////////////////////////////////////////////////////////////
  // Decode
  assign csr_sel = (io_addr_i == FSPC_CSR_ADDR);
  assign csr_wr = io_we_i && csr_sel;
  assign busy_op = (state_reg == FSPC_ERASING) || (state_reg == FSPC_WRITING);
  assign legal_wr = (io_wdata_i[4:0] == FSPC_CMD_STORE) || (io_wdata_i[4:0] == FSPC_CMD_ERASE) ||
                    (io_wdata_i[4:0] == FSPC_CMD_WRITE) || (io_wdata_i[4:0] == FSPC_CMD_LFREAD) ||
                    (io_wdata_i[4:0] == FSPC_CMD_RWWRE); // [RULE22]
  assign store_ok = (state_reg == FSPC_ARMED) && store_instr_i && !ee_busy_reg; // [RULE23]
  assign lf_armed = (state_reg == FSPC_ARMED) && (cmd_reg == FSPC_CMD_LFREAD) &&
                    (win_reg > (FSPC_STORE_WIN - FSPC_LOAD_WIN)) && !ee_busy_reg; // [RULE1] [RULE23]
  assign lf_hit = lf_armed && load_instr_i;
  assign op_start = store_ok && ((cmd_reg == FSPC_CMD_ERASE) || (cmd_reg == FSPC_CMD_WRITE));
  assign buf_clear = csr_wr && (state_reg == FSPC_IDLE) && !ee_busy_reg &&
                     (io_wdata_i[4:0] == FSPC_CMD_RWWRE); // [RULE14] [RULE22]
  ////////////////////////////////////////////////////////////
  // Command arming and auto-clear; op state survives reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i && !busy_op) begin
      state_reg <= FSPC_IDLE;
      cmd_reg <= 5'h00;
      win_reg <= 3'h0;
    end else begin
      case (state_reg)
        FSPC_IDLE: begin
          if (csr_wr && legal_wr && !ee_busy_reg) begin // [RULE22] [RULE23]
            state_reg <= FSPC_ARMED;
            cmd_reg <= io_wdata_i[4:0];
            win_reg <= FSPC_STORE_WIN; // [RULE21]
          end
        end
        FSPC_ARMED: begin
          if (op_start) begin
            state_reg <= (cmd_reg == FSPC_CMD_ERASE) ? FSPC_ERASING : FSPC_WRITING; // [RULE16] [RULE18]
          end else if (store_ok || lf_hit || win_reg == 3'h1) begin
            state_reg <= FSPC_IDLE; // [RULE2] [RULE17] [RULE19] [RULE21]
            cmd_reg <= 5'h00;
          end
          win_reg <= win_reg - 3'h1;
        end
        FSPC_ERASING, FSPC_WRITING: begin
          if (op_done) begin
            state_reg <= FSPC_IDLE; // [RULE8] [RULE17] [RULE19]
            cmd_reg <= 5'h00;
          end
        end
        default: begin
          state_reg <= FSPC_IDLE;
          cmd_reg <= 5'h00;
        end
      endcase
    end
  end
  fspc_op_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .start_i(op_start),
    .done_o(op_done)
  ); // [RULE9]
  ////////////////////////////////////////////////////////////
  // Interrupt enable bit; read-only bits ignored
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_en_reg <= FSPC_CSR_RESET[FSPC_BIT_IE];
    end else if (csr_wr) begin
      irq_en_reg <= io_wdata_i[FSPC_BIT_IE]; // [RULE26]
    end
  end
  ////////////////////////////////////////////////////////////
  // Temporary page buffer
  always_comb begin
    bw.we = store_ok && (cmd_reg == FSPC_CMD_STORE) && !buf_valid_reg[zptr_i[FSPC_WORD_AW:1]]; // [RULE20]
    bw.word = zptr_i[FSPC_WORD_AW:1]; // [RULE20]
    bw.data = r1r0_i;
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || buf_clear || (op_done && state_reg == FSPC_WRITING)) begin
      buf_valid_reg <= '0; // [RULE14] [RULE24]
    end else if (bw.we) begin
      buf_valid_reg[bw.word] <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (bw.we) begin
      page_buf[bw.word] <= bw.data;
    end
  end
  ////////////////////////////////////////////////////////////
  // Flash array strobes and write-data stream
  always_ff @(posedge sys_clk_i) begin
    if (rst_i && !busy_op) begin
      page_erase_o <= 1'b0;
      page_write_o <= 1'b0;
      page_addr_o <= 16'h0000;
      cpu_halt_o <= 1'b0;
      buf_rd_idx_o <= '0;
      buf_word_o <= 16'h0000;
    end else begin
      page_erase_o <= op_start && (cmd_reg == FSPC_CMD_ERASE); // [RULE18]
      page_write_o <= op_start && (cmd_reg == FSPC_CMD_WRITE); // [RULE16]
      if (op_start) begin
        page_addr_o <= {zptr_i[15:FSPC_WORD_AW+1], {(FSPC_WORD_AW+1){1'b0}}}; // [RULE16] [RULE18]
      end
      if (op_start) begin
        cpu_halt_o <= 1'b1; // [RULE17] [RULE19]
      end else if (op_done) begin
        cpu_halt_o <= 1'b0;
      end
      if (state_reg == FSPC_WRITING) begin
        buf_rd_idx_o <= buf_rd_idx_o + 1'b1;
        buf_word_o <= buf_valid_reg[buf_rd_idx_o] ? page_buf[buf_rd_idx_o] : 16'hFFFF;
      end else begin
        buf_rd_idx_o <= '0;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  // Load data: lock or fuse bytes when armed, else program byte
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      load_data_o <= 8'h00;
      load_valid_o <= 1'b0;
    end else begin
      load_valid_o <= load_instr_i;
      if (lf_hit) begin
        if (!zptr_i[0]) begin // [RULE15]
          load_data_o <= (zptr_i == FSPC_Z_FUSE_EXT) ? fuses_i.fuse_ext : fuses_i.fuse_lo; // [RULE4] [RULE6] [RULE7]
        end else begin
          load_data_o <= (zptr_i == FSPC_Z_FUSE_HI) ? fuses_i.fuse_hi : fuses_i.lock; // [RULE1] [RULE5] [RULE7]
        end
      end else if (load_instr_i) begin
        load_data_o <= prog_byte_i; // [RULE3]
      end
    end
  end
  ////////////////////////////////////////////////////////////
  // Register read and ready interrupt
  always_comb begin
    csr_view = 8'h00;
    csr_view[FSPC_BIT_IE] = irq_en_reg;
    csr_view[FSPC_BIT_BUSY] = 1'b0; // [RULE10]
    csr_view[FSPC_BIT_RES] = 1'b0; // [RULE11]
    csr_view[4:0] = (state_reg == FSPC_IDLE) ? 5'h00 : cmd_reg;
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      io_rdata_o <= 8'h00;
      ready_irq_o <= 1'b0;
    end else begin
      io_rdata_o <= (io_re_i && csr_sel) ? csr_view : 8'h00;
      ready_irq_o <= irq_en_reg && gie_reg && (state_reg == FSPC_IDLE) && !ee_busy_reg; // [RULE12] [RULE13]
    end
  end
endmodule : fspc_top

// ### fspc_top_checker.sv
// Assertion checker for flash self-program control ports
`timescale 1ns/1ps
module fspc_top_checker (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic io_we_i,
  input wire logic [5:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic load_instr_i,
  input wire logic [15:0] zptr_i,
  input wire logic [7:0] prog_byte_i,
  input wire fspc_pkg::fspc_fuses_t fuses_i,
  input wire logic [7:0] load_data_o,
  input wire logic load_valid_o,
  input wire logic cpu_halt_o,
  input wire logic ready_irq_o,
  input wire logic page_erase_o,
  input wire logic page_write_o
);
  import fspc_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence lock_arm;
    io_we_i && io_addr_i == FSPC_CSR_ADDR && io_wdata_i[4:0] == FSPC_CMD_LFREAD ##1 load_instr_i && zptr_i == FSPC_Z_LOCK;
  endsequence
  sequence quiet_load;
    !io_we_i [*4] ##0 load_instr_i;
  endsequence
  chk_res_bits_zero: assert property (io_rdata_o[6:5] == 2'h0)
    else $error("status bits 6 or 5 set");
  chk_load_valid_cause: assert property (load_valid_o |-> $past(load_instr_i))
    else $error("load result without load");
  chk_lock_read_data: assert property (lock_arm |=> load_data_o == $past(fuses_i.lock))
    else $error("lock bits not returned");
  chk_normal_load: assert property (quiet_load |=> load_data_o == $past(prog_byte_i))
    else $error("unarmed load not program byte");
  chk_halt_follows: assert property (page_erase_o || page_write_o |=> cpu_halt_o)
    else $error("no halt after start");
  chk_halt_cause: assert property ($rose(cpu_halt_o) |-> page_erase_o || page_write_o)
    else $error("halt without start");
  chk_halt_holds: assert property ($rose(cpu_halt_o) |=> cpu_halt_o [*8])
    else $error("operation too short");
  chk_irq_busy_off: assert property (cpu_halt_o |-> !ready_irq_o)
    else $error("ready interrupt during store");
endmodule : fspc_top_checker
bind fspc_top fspc_top_checker u_chk (.sys_clk_i, .rst_i, .io_we_i, .io_addr_i, .io_wdata_i, .io_rdata_o,
  .load_instr_i, .zptr_i, .prog_byte_i, .fuses_i, .load_data_o, .load_valid_o, .cpu_halt_o, .ready_irq_o,
  .page_erase_o, .page_write_o);

// ### fspc_cpu_model.sv
// Core-side model issuing timed store and load instructions
`timescale 1ns/1ps
module fspc_cpu_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic is_load_i,
  input wire logic [2:0] gap_i,
  output logic store_instr_o,
  output logic load_instr_o
);
  logic [2:0] cnt_reg;
  logic pulse_reg;
  logic load_reg;
  // Instruction lands gap cycles after the control write
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_reg <= 3'h0;
      pulse_reg <= 1'b0;
    end else if (go_i) begin
      cnt_reg <= (gap_i == 3'h0) ? 3'h0 : gap_i - 3'h1;
      pulse_reg <= (gap_i == 3'h1);
    end else begin
      cnt_reg <= (cnt_reg != 3'h0) ? cnt_reg - 3'h1 : 3'h0;
      pulse_reg <= (cnt_reg == 3'h1);
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (go_i) begin
      load_reg <= is_load_i;
    end
  end
  assign store_instr_o = pulse_reg & ~load_reg;
  assign load_instr_o = pulse_reg & load_reg;
endmodule : fspc_cpu_model

// ### tb.sv
// Self-checking bench for flash self-program control
`timescale 1ns/1ps
module tb;
  import fspc_pkg::*;
  logic sys_clk_i, rst_i, we, re, go, ld, st_i, ld_i, gie, ee, halt, irq, ers, lv, pw;
  logic [4:0] bidx;
  logic [2:0] gap;
  logic [5:0] addr;
  logic [7:0] wd, rdata, ldata;
  logic [15:0] zptr, paddr;
  fspc_fuses_t fuses;
  int n_fail, comparisons;
  fspc_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .io_we_i(we), .io_re_i(re), .io_addr_i(addr),
    .io_wdata_i(wd), .io_rdata_o(rdata), .store_instr_i(st_i), .load_instr_i(ld_i), .zptr_i(zptr),
    .r1r0_i(16'h0000), .prog_byte_i(8'hA5), .global_irq_en_i(gie), .eeprom_write_busy_i(ee), .fuses_i(fuses),
    .load_data_o(ldata), .load_valid_o(lv), .cpu_halt_o(halt), .ready_irq_o(irq), .page_erase_o(ers),
    .page_write_o(pw), .page_addr_o(paddr), .buf_word_o(), .buf_rd_idx_o(bidx));
  fspc_cpu_model cpu (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .go_i(go), .is_load_i(ld), .gap_i(gap),
    .store_instr_o(st_i), .load_instr_o(ld_i));
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : idle
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic l, input logic [2:0] g);
    @(posedge sys_clk_i);
    we <= 1'b1;
    addr <= a;
    wd <= d;
    go <= 1'b1;
    ld <= l;
    gap <= g;
    @(posedge sys_clk_i);
    we <= 1'b0;
    go <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] exp);
    @(posedge sys_clk_i);
    re <= 1'b1;
    addr <= FSPC_CSR_ADDR;
    @(posedge sys_clk_i);
    re <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(FSPC_CSR_RESET);
    wr(FSPC_CSR_ADDR, 8'hE7, 1'b0, 3'h0);
    rd(8'h80);
    wr(6'h36, 8'h01, 1'b0, 3'h0);
    rd(8'h80);
    gie <= 1'b1;
    idle(6);
    chk({15'h0, irq}, 16'h0001);
    ee <= 1'b1;
    idle(6);
    chk({15'h0, irq}, 16'h0000);
    zptr <= FSPC_Z_FUSE_EXT;
    wr(FSPC_CSR_ADDR, 8'h09, 1'b1, 3'h1);
    idle(6);
    chk({8'h00, ldata}, 16'h00A5);
    ee <= 1'b0;
    idle(4);
  endtask : t_regs
  task automatic t_fuses;
    logic [7:0] exp [4];
    exp = '{fuses.fuse_lo, fuses.lock, fuses.fuse_ext, fuses.fuse_hi};
    for (int z = 0; z < 4; z++) begin
      zptr <= 16'(z);
      wr(FSPC_CSR_ADDR, 8'h09, 1'b1, 3'h1);
      @(posedge sys_clk_i);
      #1;
      chk({15'h0, lv}, 16'h0001);
      idle(3);
      chk({8'h00, ldata}, {8'h00, exp[z]});
      rd(8'h00);
    end
    wr(FSPC_CSR_ADDR, 8'h09, 1'b1, 3'h4);
    idle(6);
    chk({8'h00, ldata}, 16'h00A5);
  endtask : t_fuses
  task automatic t_timeout;
    wr(FSPC_CSR_ADDR, 8'h01, 1'b0, 3'h5);
    idle(6);
    rd(8'h00);
    wr(FSPC_CSR_ADDR, 8'h03, 1'b0, 3'h5);
    idle(6);
    chk({15'h0, halt}, 16'h0000);
    rd(8'h00);
  endtask : t_timeout
  task automatic t_erase;
    int i;
    zptr <= 16'h1234;
    wr(FSPC_CSR_ADDR, 8'h03, 1'b0, 3'h4);
    for (i = 0; i < 10; i++) begin
      @(posedge sys_clk_i);
      #1;
      if (ers === 1'b1) break;
    end
    chk({15'h0, ers}, 16'h0001);
    chk(paddr, 16'h1200);
    chk({15'h0, pw}, 16'h0000);
    chk({11'h0, bidx}, 16'h0000);
    rd(8'h03);
    chk({15'h0, halt}, 16'h0001);
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    idle(2);
    chk({15'h0, halt}, 16'h0001);
  endtask : t_erase
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #100000;
    n_fail++;
    wrap_up;
  end
  initial begin
    rst_i = 1'b1;
    {we, re, go, ld, gie, ee} = 6'h00;
    gap = 3'h0;
    addr = FSPC_CSR_ADDR;
    wd = 8'h00;
    zptr = 16'h0000;
    fuses = '{8'hC3, 8'h62, 8'hDF, 8'hF9};
    n_fail = 0;
    comparisons = 0;
    idle(16);
    rst_i <= 1'b0;
    t_regs;
    t_fuses;
    t_timeout;
    t_erase;
    wrap_up;
  end
endmodule : tb
